// [pkg/tmr8_pkg.sv]
// Constants and types for the 8-bit timer with its register front end.
// Assumes a word-addressed AXI4-Lite map: byte address is four times the index.
package tmr8_pkg;
  // Register indexes
  localparam logic [7:0] TMR8_IDX_CTRL_A = 8'h44;
  localparam logic [7:0] TMR8_IDX_CTRL_B = 8'h45;
  localparam logic [7:0] TMR8_IDX_CNT = 8'h46;
  localparam logic [7:0] TMR8_IDX_CMP_A = 8'h47;
  localparam logic [7:0] TMR8_IDX_CMP_B = 8'h48;
  localparam logic [7:0] TMR8_IDX_MASK = 8'h6e;
  localparam logic [7:0] TMR8_IDX_FLAGS = 8'h6f;
  // Bit positions
  localparam int TMR8_FORCE_A_BIT = 7;
  localparam int TMR8_FORCE_B_BIT = 6;
  localparam int TMR8_WAVE_UP_BIT = 3;
  localparam int TMR8_CMPB_BIT = 2;
  localparam int TMR8_CMPA_BIT = 1;
  localparam int TMR8_OVF_BIT = 0;
  // Values after reset
  localparam logic [7:0] TMR8_REG_RST = 8'h00;
  localparam logic [2:0] TMR8_IRQ_RST = 3'h0;
  // Clock select codes
  localparam logic [2:0] TMR8_CS_STOP = 3'h0;
  localparam logic [2:0] TMR8_CS_DIV1 = 3'h1;
  localparam logic [2:0] TMR8_CS_DIV8 = 3'h2;
  localparam logic [2:0] TMR8_CS_DIV64 = 3'h3;
  localparam logic [2:0] TMR8_CS_DIV256 = 3'h4;
  localparam logic [2:0] TMR8_CS_DIV1024 = 3'h5;
  localparam logic [2:0] TMR8_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TMR8_CS_EXT_RISE = 3'h7;
  // Prescaler terminal counts (divisor minus one)
  localparam logic [9:0] TMR8_PRE_M8 = 10'h007;
  localparam logic [9:0] TMR8_PRE_M64 = 10'h03f;
  localparam logic [9:0] TMR8_PRE_M256 = 10'h0ff;
  localparam logic [9:0] TMR8_PRE_M1024 = 10'h3ff;
  // Waveform modes
  localparam logic [2:0] TMR8_WM_NORMAL = 3'h0;
  localparam logic [2:0] TMR8_WM_CLR_MATCH = 3'h2;
  localparam logic [2:0] TMR8_WM_PC_TOPA = 3'h5;
  localparam logic [2:0] TMR8_WM_FAST_TOPA = 3'h7;
  localparam logic [7:0] TMR8_MAX = 8'hff;
  localparam logic [7:0] TMR8_BOTTOM = 8'h00;
  // Output actions
  localparam logic [1:0] TMR8_ACT_OFF = 2'h0;
  localparam logic [1:0] TMR8_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TMR8_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TMR8_ACT_SET = 2'h3;
  // AXI responses
  localparam logic [1:0] TMR8_RESP_OKAY = 2'h0;
  localparam logic [1:0] TMR8_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic [2:0] wave_mode;
    logic [2:0] clk_sel;
  } tmr8_ctrl_t;
endpackage : tmr8_pkg

// [core/tmr8_timer.sv]
// 8-bit timer/counter with prescaler, two compare channels and flag logic.
// Assumes an AXI4-Lite master on ref_clk and a synchronous external count pin.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module tmr8_timer
  import tmr8_pkg::*;
(
  input wire logic ref_clk, // 20 MHz clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [11:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [11:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic external_count_pin, // External count input
  input wire logic global_irq_enable, // Global interrupt enable from status word
  input wire logic [2:0] irq_ack, // Vector acknowledge per source
  output logic [2:0] irq_req, // Interrupt requests per source
  output logic wave_output_a, // Waveform A
  output logic wave_output_b, // Waveform B
  output logic wave_drive_a_n, // Low while waveform A owns its pin
  output logic wave_drive_b_n // Low while waveform B owns its pin
);
  tmr8_ctrl_t ctrl_ff;
  logic [7:0] cnt_ff, cmp_a_buf_ff, cmp_b_buf_ff, cmp_a_ff, cmp_b_ff;
  logic [2:0] mask_ff, flags_ff, irq_req_ff;
  logic [9:0] pre_ff;
  logic ext_prev_ff, dir_down_ff, block_ff;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_got_ff, w_got_ff, wstrb0_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [7:0] rdata_ff, wdata_ff;
  logic [11:0] awaddr_ff;
  logic [1:0] wave_ff, drive_n_ff;

  function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] idx);
    reg_hit = (addr[11:2] == {2'h0, idx});
  endfunction : reg_hit

  function automatic logic mapped(input logic [11:0] a);
    mapped = reg_hit(a, TMR8_IDX_CTRL_A) | reg_hit(a, TMR8_IDX_CTRL_B) |
             reg_hit(a, TMR8_IDX_CNT) | reg_hit(a, TMR8_IDX_CMP_A) |
             reg_hit(a, TMR8_IDX_CMP_B) | reg_hit(a, TMR8_IDX_MASK) |
             reg_hit(a, TMR8_IDX_FLAGS);
  endfunction : mapped

  // Odd modes are the PWM ones
  function automatic logic is_pwm(input logic [2:0] m);
    is_pwm = m[0];
  endfunction : is_pwm

  // Next waveform level for one channel
  function automatic logic wave_next(input logic cur, input logic [1:0] act,
      input logic [2:0] m, input logic hit, input logic frc, input logic wrap,
      input logic up, input logic chan_a);
    logic res;
    res = cur;
    if (!is_pwm(m)) begin
      if (hit || frc) begin
        case (act)
          TMR8_ACT_TOGGLE: res = ~cur;
          TMR8_ACT_CLEAR: res = 1'b0;
          TMR8_ACT_SET: res = 1'b1;
          default: res = cur;
        endcase
      end
    end else if (act == TMR8_ACT_TOGGLE) begin
      if (chan_a && m[2] && hit) begin
        res = ~cur;
      end
    end else if (act[1] && m[1]) begin
      // Bottom wins, so a compare equal to top is ignored
      if (wrap) begin
        res = ~act[0];
      end else if (hit) begin
        res = act[0];
      end
    end else if (act[1] && hit) begin
      res = up ? act[0] : ~act[0];
    end
    wave_next = res;
  endfunction : wave_next

  // Bus write strobes
  logic wr_go, wr_ok;
  logic wr_ctrl_a, wr_ctrl_b, wr_cnt, wr_cmp_a, wr_cmp_b, wr_mask, wr_flags;
  assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_ok = wr_go && wstrb0_ff && mapped(awaddr_ff);
  assign wr_ctrl_a = wr_ok && reg_hit(awaddr_ff, TMR8_IDX_CTRL_A);
  assign wr_ctrl_b = wr_ok && reg_hit(awaddr_ff, TMR8_IDX_CTRL_B);
  assign wr_cnt = wr_ok && reg_hit(awaddr_ff, TMR8_IDX_CNT);
  assign wr_cmp_a = wr_ok && reg_hit(awaddr_ff, TMR8_IDX_CMP_A);
  assign wr_cmp_b = wr_ok && reg_hit(awaddr_ff, TMR8_IDX_CMP_B);
  assign wr_mask = wr_ok && reg_hit(awaddr_ff, TMR8_IDX_MASK);
  assign wr_flags = wr_ok && reg_hit(awaddr_ff, TMR8_IDX_FLAGS);

  // Write channel: address and data taken in either order
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= TMR8_RESP_OKAY;
      awaddr_ff <= 12'h000;
      wdata_ff <= TMR8_REG_RST;
      wstrb0_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata[7:0];
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= mapped(awaddr_ff) ? TMR8_RESP_OKAY : TMR8_RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // Read data mux; reserved and strobe bits read as zero
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    if (reg_hit(s_axi_araddr, TMR8_IDX_CTRL_A)) begin
      rd_val = {ctrl_ff.act_a, ctrl_ff.act_b, 2'h0, ctrl_ff.wave_mode[1:0]};
    end
    if (reg_hit(s_axi_araddr, TMR8_IDX_CTRL_B)) begin
      rd_val = {4'h0, ctrl_ff.wave_mode[2], ctrl_ff.clk_sel};
    end
    if (reg_hit(s_axi_araddr, TMR8_IDX_CNT)) begin
      rd_val = cnt_ff;
    end
    if (reg_hit(s_axi_araddr, TMR8_IDX_CMP_A)) begin
      rd_val = cmp_a_buf_ff;
    end
    if (reg_hit(s_axi_araddr, TMR8_IDX_CMP_B)) begin
      rd_val = cmp_b_buf_ff;
    end
    if (reg_hit(s_axi_araddr, TMR8_IDX_MASK)) begin
      rd_val = {5'h00, mask_ff};
    end
    if (reg_hit(s_axi_araddr, TMR8_IDX_FLAGS)) begin
      rd_val = {5'h00, flags_ff};
    end
  end

  // Read channel: one cycle from address to data
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= TMR8_REG_RST;
      rresp_ff <= TMR8_RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_val;
      rresp_ff <= mapped(s_axi_araddr) ? TMR8_RESP_OKAY : TMR8_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // Control fields, mask
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl_ff <= '0;
      mask_ff <= TMR8_IRQ_RST;
    end else begin
      if (wr_ctrl_a) begin
        ctrl_ff.act_a <= wdata_ff[7:6];
        ctrl_ff.act_b <= wdata_ff[5:4];
        ctrl_ff.wave_mode[1:0] <= wdata_ff[1:0];
      end
      if (wr_ctrl_b) begin
        ctrl_ff.wave_mode[2] <= wdata_ff[TMR8_WAVE_UP_BIT];
        ctrl_ff.clk_sel <= wdata_ff[2:0];
      end
      if (wr_mask) begin
        mask_ff <= wdata_ff[2:0];
      end
    end
  end

  // Free-running prescaler shared by all divided rates
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pre_ff <= 10'h000;
      ext_prev_ff <= 1'b0;
    end else begin
      pre_ff <= pre_ff + 10'h001;
      ext_prev_ff <= external_count_pin;
    end
  end

  // timer tick select; pin direction is irrelevant here
  logic tick;
  always_comb begin
    unique case (ctrl_ff.clk_sel)
      TMR8_CS_STOP: tick = 1'b0;
      TMR8_CS_DIV1: tick = 1'b1;
      TMR8_CS_DIV8: tick = (pre_ff & TMR8_PRE_M8) == TMR8_PRE_M8;
      TMR8_CS_DIV64: tick = (pre_ff & TMR8_PRE_M64) == TMR8_PRE_M64;
      TMR8_CS_DIV256: tick = (pre_ff & TMR8_PRE_M256) == TMR8_PRE_M256;
      TMR8_CS_DIV1024: tick = pre_ff == TMR8_PRE_M1024;
      TMR8_CS_EXT_FALL: tick = ext_prev_ff && !external_count_pin;
      TMR8_CS_EXT_RISE: tick = !ext_prev_ff && external_count_pin;
    endcase
  end

  logic [2:0] mode;
  logic [7:0] top;
  logic pc_mode, fast_mode, at_top, wrap, ovf_evt;
  assign mode = ctrl_ff.wave_mode;
  assign pc_mode = mode[0] && !mode[1];
  assign fast_mode = mode[0] && mode[1];
  assign top = (mode == TMR8_WM_CLR_MATCH || mode == TMR8_WM_PC_TOPA ||
                mode == TMR8_WM_FAST_TOPA) ? cmp_a_ff : TMR8_MAX;
  assign at_top = cnt_ff == top;
  assign wrap = tick && !pc_mode && at_top;
  assign ovf_evt = tick && (pc_mode ? (dir_down_ff && cnt_ff == TMR8_BOTTOM) :
                   (mode == TMR8_WM_FAST_TOPA) ? at_top : cnt_ff == TMR8_MAX);

  // compare, blocked on the tick after a counter write
  logic [1:0] chan_hit, chan_frc;
  assign chan_hit[0] = tick && !block_ff && cnt_ff == cmp_a_ff;
  assign chan_hit[1] = tick && !block_ff && cnt_ff == cmp_b_ff;
  // strobes act once, only in non-PWM modes
  assign chan_frc[0] = wr_ctrl_b && wdata_ff[TMR8_FORCE_A_BIT] && !is_pwm(mode);
  assign chan_frc[1] = wr_ctrl_b && wdata_ff[TMR8_FORCE_B_BIT] && !is_pwm(mode);

  // Counter; a bus write beats counting. strobes never touch it
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cnt_ff <= TMR8_REG_RST;
      dir_down_ff <= 1'b0;
      block_ff <= 1'b0;
    end else if (wr_cnt) begin
      cnt_ff <= wdata_ff;
      block_ff <= 1'b1;
    end else if (tick) begin
      block_ff <= 1'b0;
      if (!pc_mode) begin
        cnt_ff <= at_top ? TMR8_BOTTOM : cnt_ff + 8'h01;
      end else if (!dir_down_ff) begin
        cnt_ff <= at_top ? cnt_ff - 8'h01 : cnt_ff + 8'h01;
        dir_down_ff <= at_top;
      end else begin
        cnt_ff <= (cnt_ff == TMR8_BOTTOM) ? cnt_ff + 8'h01 : cnt_ff - 8'h01;
        dir_down_ff <= cnt_ff != TMR8_BOTTOM;
      end
    end
  end

  // compare buffers: immediate, at top or at bottom by mode
  logic cmp_load;
  assign cmp_load = !is_pwm(mode) ||
                    (pc_mode ? tick && at_top && !dir_down_ff : fast_mode && wrap);
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cmp_a_buf_ff <= TMR8_REG_RST;
      cmp_b_buf_ff <= TMR8_REG_RST;
      cmp_a_ff <= TMR8_REG_RST;
      cmp_b_ff <= TMR8_REG_RST;
    end else begin
      if (wr_cmp_a) begin
        cmp_a_buf_ff <= wdata_ff;
      end
      if (wr_cmp_b) begin
        cmp_b_buf_ff <= wdata_ff;
      end
      if (cmp_load) begin
        cmp_a_ff <= wr_cmp_a ? wdata_ff : cmp_a_buf_ff;
        cmp_b_ff <= wr_cmp_b ? wdata_ff : cmp_b_buf_ff;
      end
    end
  end

  // flags: a set in the clear cycle wins
  logic [2:0] flag_set, flag_clr;
  assign flag_set = {chan_hit[1], chan_hit[0], ovf_evt};
  assign flag_clr = irq_ack | (wr_flags ? wdata_ff[2:0] : 3'h0);
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flags_ff <= TMR8_IRQ_RST;
    end else begin
      flags_ff <= (flags_ff & ~flag_clr) | flag_set;
    end
  end

  // request gating, registered to keep outputs on flops
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq_req_ff <= TMR8_IRQ_RST;
    end else begin
      irq_req_ff <= flags_ff & mask_ff & {3{global_irq_enable}};
    end
  end

  // waveform units, channel 0 is A and 1 is B
  for (genvar i = 0; i < 2; i++) begin : g_wave
    logic [1:0] act;
    assign act = (i == 0) ? ctrl_ff.act_a : ctrl_ff.act_b;
    always_ff @(posedge ref_clk) begin
      if (!nrst) begin
        wave_ff[i] <= 1'b0;
        drive_n_ff[i] <= 1'b1;
      end else begin
        wave_ff[i] <= wave_next(wave_ff[i], act, mode, chan_hit[i], chan_frc[i],
                                wrap, !dir_down_ff, i == 0);
        drive_n_ff[i] <= act == TMR8_ACT_OFF;
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = {24'h00_0000, rdata_ff};
  assign irq_req = irq_req_ff;
  assign wave_output_a = wave_ff[0];
  assign wave_output_b = wave_ff[1];
  assign wave_drive_a_n = drive_n_ff[0];
  assign wave_drive_b_n = drive_n_ff[1];

  // Checks on the timer core
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  force_a_out_a: assert property (
    (chan_frc[0] && !chan_hit[0] && ctrl_ff.act_a == TMR8_ACT_SET) |=> wave_ff[0])
    else $error("force A did not set output A");
  force_b_out_a: assert property (
    (chan_frc[1] && !chan_hit[1] && ctrl_ff.act_b == TMR8_ACT_CLEAR) |=> !wave_ff[1])
    else $error("force B did not clear output B");
  force_no_flag_a: assert property (
    (wr_ctrl_b && !chan_hit[0] && !chan_hit[1]) |=> !$rose(flags_ff[2]) && !$rose(flags_ff[1]))
    else $error("force strobe raised a compare flag");
  ctrl_b_read_a: assert property (
    (s_axi_arvalid && arready_ff && reg_hit(s_axi_araddr, TMR8_IDX_CTRL_B))
      |=> rvalid_ff && rdata_ff[7:4] == 4'h0)
    else $error("control B upper bits read non-zero");
  stop_hold_a: assert property (
    (ctrl_ff.clk_sel == TMR8_CS_STOP && !wr_cnt) |=> $stable(cnt_ff))
    else $error("stopped counter moved");
  div8_tick_a: assert property (
    (ctrl_ff.clk_sel == TMR8_CS_DIV8 && tick) |-> pre_ff[2:0] == 3'h7)
    else $error("divide-by-8 tick misaligned");
  ext_rise_a: assert property (
    (ctrl_ff.clk_sel == TMR8_CS_EXT_RISE && !ext_prev_ff && external_count_pin &&
     mode == TMR8_WM_NORMAL && !wr_cnt) |=> cnt_ff == 8'($past(cnt_ff) + 8'h01))
    else $error("rising pin edge did not count");
  write_block_a: assert property (
    wr_cnt ##1 (tick && !wr_cnt) |-> chan_hit == 2'h0)
    else $error("match not blocked after counter write");
  cmp_a_flag_a: assert property (
    chan_hit[0] |=> flags_ff[TMR8_CMPA_BIT])
    else $error("compare A flag not set");
  w1c_b_a: assert property (
    (wr_flags && wdata_ff[TMR8_CMPB_BIT] && !chan_hit[1]) |=> !flags_ff[TMR8_CMPB_BIT])
    else $error("compare B flag not cleared by write");
  ovf_flag_a: assert property (
    ovf_evt |=> flags_ff[TMR8_OVF_BIT])
    else $error("overflow flag not set");
  irq_gate_a: assert property (
    irq_req_ff[0] |-> $past(flags_ff[0]) && $past(mask_ff[0]) && $past(global_irq_enable))
    else $error("overflow request without cause");
  ack_clear_a: assert property (
    (irq_ack[1] && !chan_hit[0]) |=> !flags_ff[TMR8_CMPA_BIT])
    else $error("acknowledge did not clear compare A flag");
  match_clear_a: assert property (
    (tick && mode == TMR8_WM_CLR_MATCH && at_top && !wr_cnt) |=> cnt_ff == TMR8_BOTTOM)
    else $error("clear-on-match did not clear");
  toggle_a: assert property (
    (mode == TMR8_WM_NORMAL && ctrl_ff.act_a == TMR8_ACT_TOGGLE && chan_hit[0])
      |=> wave_ff[0] != $past(wave_ff[0]))
    else $error("toggle action failed");

  force_seen_c: cover property (chan_frc[0] && ctrl_ff.act_a != TMR8_ACT_OFF);
  ovf_seen_c: cover property (ovf_evt && mode == TMR8_WM_NORMAL);
  pc_turn_c: cover property (pc_mode && tick && at_top);
  ext_count_c: cover property (ctrl_ff.clk_sel == TMR8_CS_EXT_FALL && tick);
endmodule : tmr8_timer
`default_nettype wire

// [tb/tmr8_irq_partner.sv]
// Interrupt controller model that acknowledges every pending request.
// Assumes irq_req is a level that drops once its flag has been cleared.
`timescale 1ns/10ps
`default_nettype none
module tmr8_irq_partner (
  input wire logic ref_clk, // 20 MHz clock
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [2:0] irq_req, // Requests from the timer
  output logic [2:0] irq_ack // One-cycle vector acknowledge
);
  // one-cycle acknowledge
  // Never two cycles in a row, so a flag that sets again is not swallowed
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq_ack <= 3'h0;
    end else begin
      irq_ack <= irq_req & ~irq_ack;
    end
  end
endmodule : tmr8_irq_partner
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the 8-bit timer and its AXI4-Lite registers.
// Assumes the partner model acknowledges every interrupt request.
`timescale 1ns/10ps
`default_nettype none
module testbench
  import tmr8_pkg::*;
;
  logic ref_clk, nrst, awv, wv, bry, arv, rry, pin, gie;
  logic aw_rdy, w_rdy, ar_rdy, b_vld, r_vld, wa, wb, drv_a_n, drv_b_n;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdata, rdat;
  logic [1:0] br, rr;
  logic [2:0] req, ack;
  logic [7:0] v;
  int fail_count, samples_checked, n;
  logic [7:0] regs [7] = '{TMR8_IDX_CTRL_A, TMR8_IDX_CTRL_B, TMR8_IDX_CNT, TMR8_IDX_CMP_A,
    TMR8_IDX_CMP_B, TMR8_IDX_MASK, TMR8_IDX_FLAGS};
  logic [1:0] acts [4] = '{TMR8_ACT_SET, TMR8_ACT_CLEAR, TMR8_ACT_TOGGLE, TMR8_ACT_OFF};

  tmr8_timer i_dut (.ref_clk(ref_clk), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(aw_rdy), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
    .s_axi_wready(w_rdy), .s_axi_bresp(br), .s_axi_bvalid(b_vld), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ar_rdy), .s_axi_rdata(rdata),
    .s_axi_rresp(rr), .s_axi_rvalid(r_vld), .s_axi_rready(rry), .external_count_pin(pin),
    .global_irq_enable(gie), .irq_ack(ack), .irq_req(req), .wave_output_a(wa),
    .wave_output_b(wb), .wave_drive_a_n(drv_a_n), .wave_drive_b_n(drv_b_n));
  tmr8_irq_partner i_irq (.ref_clk(ref_clk), .nrst(nrst), .irq_req(req), .irq_ack(ack));

  // Readback of a register: reserved bits and strobes read as zero
  function automatic logic [7:0] exp_rd(input logic [7:0] idx, input logic [7:0] d);
    if (idx == TMR8_IDX_CTRL_B) return d & 8'h0f;
    if (idx == TMR8_IDX_MASK) return d & 8'h07;
    return d;
  endfunction : exp_rd
  // Divisor of a clock select code
  function automatic int div_of(input int c);
    case (c)
      1: return 1;
      2: return 8;
      3: return 64;
      4: return 256;
      default: return 1024;
    endcase
  endfunction : div_of
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Count taken at a moment the bench only bounds, so checked as a range
  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
    samples_checked++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      fail_count++;
      $display("mismatch %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask : chk_rng
  // Both channels offered together, each released once taken
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d,
    input logic [1:0] er = TMR8_RESP_OKAY);
    @(posedge ref_clk);
    awa <= 12'({idx, 2'b00});
    wd <= 32'(d);
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    // Only the watchdog ends a wait for the response
    do begin
      @(posedge ref_clk);
      if (aw_rdy) awv <= 1'b0;
      if (w_rdy) wv <= 1'b0;
    end while (!b_vld);
    bry <= 1'b0;
    chk("bresp", er, br);
  endtask : reg_wr
  // An empty name skips the data compare; data stays in rdat
  task automatic reg_rd(input logic [7:0] idx, input logic [7:0] e, input string nm,
    input logic [1:0] er = TMR8_RESP_OKAY);
    @(posedge ref_clk);
    ara <= 12'({idx, 2'b00});
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (ar_rdy) arv <= 1'b0;
    end while (!r_vld);
    rry <= 1'b0;
    rdat = rdata;
    chk("rresp", er, rr);
    if (nm != "") chk(nm, 32'(e), rdat);
  endtask : reg_rd
  // Count pin pulses, three cycles high and four low
  task automatic pulse(input int k);
    repeat (k) begin
      @(posedge ref_clk);
      pin <= 1'b1;
      repeat (3) @(posedge ref_clk);
      pin <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask : pulse
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Free-running 50 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Watchdog well beyond the roughly 11700 cycles the tests need
  initial begin
    repeat (40000) @(posedge ref_clk);
    fail_count++;
    report_and_stop();
  end
  initial begin
    {nrst, awv, wv, bry, arv, rry, pin, gie} = '0;
    {awa, ara, wd} = '0;
    n = $urandom(46);
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (regs[i]) reg_rd(regs[i], 8'h00, "reset");
    reg_rd(8'h50, 8'h00, "unmapped", TMR8_RESP_SLVERR);
    reg_wr(8'h50, 8'hff, TMR8_RESP_SLVERR);
    $display("test reset done");
    // Random access; control B is stopped again before the counter is touched
    for (n = 0; n < 20; n++) begin
      v = 8'($urandom);
      reg_wr(regs[1 + n % 5], v);
      reg_rd(regs[1 + n % 5], exp_rd(regs[1 + n % 5], v), "rw");
      if (n % 5 == 0) reg_wr(TMR8_IDX_CTRL_B, 8'h00);
    end
    reg_wr(TMR8_IDX_FLAGS, 8'hff);
    reg_rd(TMR8_IDX_FLAGS, 8'h00, "w1c");
    $display("test random access done");
    reg_wr(TMR8_IDX_MASK, 8'h00);
    reg_wr(TMR8_IDX_CNT, 8'hf0);
    reg_wr(TMR8_IDX_CMP_A, 8'hf2);
    reg_wr(TMR8_IDX_CMP_B, 8'h20);
    reg_wr(TMR8_IDX_CTRL_B, TMR8_CS_DIV1);
    repeat (4) @(posedge ref_clk);
    reg_rd(TMR8_IDX_FLAGS, 8'h02, "flags a");
    repeat (60) @(posedge ref_clk);
    reg_rd(TMR8_IDX_FLAGS, 8'h07, "flags all");
    reg_wr(TMR8_IDX_CTRL_B, 8'h00);
    reg_wr(TMR8_IDX_MASK, 8'h07);
    repeat (3) @(posedge ref_clk);
    chk("irq_req", 3'h0, req);
    gie <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("irq_req", 3'h7, req);
    repeat (4) @(posedge ref_clk);
    reg_rd(TMR8_IDX_FLAGS, 8'h00, "acked");
    gie <= 1'b0;
    reg_wr(TMR8_IDX_MASK, 8'h00);
    $display("test flags done");
    // Clear-on-match mode with the counter sitting on compare A
    reg_wr(TMR8_IDX_CNT, 8'h11);
    reg_wr(TMR8_IDX_CMP_A, 8'h11);
    for (n = 0; n < 4; n++) begin
      reg_wr(TMR8_IDX_CTRL_A, {acts[n], acts[n], 4'h2});
      reg_wr(TMR8_IDX_CTRL_B, 8'hc0);
      repeat (2) @(posedge ref_clk);
      if (n < 3) chk("pins", {{2{~n[0]}}, 2'b00}, {wa, wb, drv_a_n, drv_b_n});
      else chk("drive_n", 2'b11, {drv_a_n, drv_b_n});
    end
    reg_rd(TMR8_IDX_CNT, 8'h11, "force cnt");
    reg_rd(TMR8_IDX_FLAGS, 8'h00, "force flags");
    reg_rd(TMR8_IDX_CTRL_B, 8'h00, "force read");
    $display("test force done");
    reg_wr(TMR8_IDX_CNT, 8'h00);
    reg_wr(TMR8_IDX_CTRL_B, TMR8_CS_EXT_RISE);
    pulse(3);
    reg_rd(TMR8_IDX_CNT, 8'h03, "ext rise");
    reg_wr(TMR8_IDX_CTRL_B, TMR8_CS_EXT_FALL);
    pulse(2);
    reg_rd(TMR8_IDX_CNT, 8'h05, "ext fall");
    $display("test external done");
    // Phase-correct, top 0xFF: overflow only at bottom, matches on the way down
    reg_wr(TMR8_IDX_CTRL_A, 8'h01);
    reg_wr(TMR8_IDX_FLAGS, 8'hff);
    reg_wr(TMR8_IDX_CNT, 8'hfe);
    reg_wr(TMR8_IDX_CTRL_B, TMR8_CS_DIV1);
    repeat (100) @(posedge ref_clk);
    reg_rd(TMR8_IDX_FLAGS, 8'h00, "pc past max");
    repeat (200) @(posedge ref_clk);
    reg_rd(TMR8_IDX_FLAGS, 8'h07, "pc bottom");
    reg_wr(TMR8_IDX_CTRL_B, 8'h00);
    reg_wr(TMR8_IDX_FLAGS, 8'h05);
    reg_rd(TMR8_IDX_FLAGS, 8'h02, "w1c some");
    $display("test phase correct done");
    reg_wr(TMR8_IDX_CTRL_A, 8'h00);
    for (n = 1; n < 6; n++) begin
      reg_wr(TMR8_IDX_CNT, 8'h00);
      reg_wr(TMR8_IDX_CTRL_B, 8'(n));
      repeat (8 * div_of(n)) @(posedge ref_clk);
      reg_wr(TMR8_IDX_CTRL_B, 8'h00);
      reg_rd(TMR8_IDX_CNT, 8'h00, "");
      chk_rng("prescale", 7, 9 + 12 / div_of(n), rdat);
    end
    $display("test prescaler done");
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
